// File: hdl/pio_card.sv
// Contract
// - Answer sixteen addresses from base only.
// - Base from six switches, default 300h.
// - Decode only inside 200h to 3FFh.
// - Interrupt edge polarity chosen by control bit.
// - Request rising edge starts transfer if enabled; the code also requires the source bit clear.
// - Acknowledge low until host transfer completes.
// - Timer pin gives pulse or square wave.
// - Low gate holds timer; open gate counts.
// - Spare control bits drive three aux pins.
// - Direction pin high for output port.
// - Offsets 0-3 ports and control registers.
// - Offsets 4-7 counters, control and status.
// - Offsets 8-A levels and status; rest unused.
// - Reset clears transfer and interrupt control.
// - Transfer request line tristated while disabled.
module pio_card
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic [9:0]  io_addr_in,
  input  wire logic        io_rd_in,
  input  wire logic        io_wr_in,
  input  wire logic [7:0]  io_wdata_in,
  input  wire logic [5:0]  base_sw_in,
  input  wire logic        dma_ack_in,
  input  wire logic        dma_tc_in,
  input  wire logic [7:0]  port_a_lines_in,
  input  wire logic [7:0]  port_b_lines_in,
  input  wire logic        irq_pin_in,
  input  wire logic        transfer_request_in,
  input  wire logic        timer_gate_in,
  output logic [7:0]       io_rdata_out,
  output logic             io_rdata_oe_out,
  output logic             dma_req_out,
  output logic             dma_req_oe_out,
  output logic             irq_out,
  output logic             irq_oe_out,
  output logic [7:0]       port_a_lines_out,
  output logic [7:0]       port_b_lines_out,
  output logic             transfer_ack_out,
  output logic             timer_out,
  output logic             dir_a_out,
  output logic             dir_b_out,
  output logic [2:0]       aux_out
);

  logic             rst_s1_ff;
  logic             rst_s2_ff;
  logic             rst_n;
  logic [5:0]       base_ff;
  logic             base_ld_ff;
  pio_pkg::pio_acc_t acc;
  logic             hit;
  logic [7:0]       port_a_ff;
  logic [7:0]       port_b_ff;
  logic [7:0]       xfer_ctl_ff;
  logic [7:0]       irq_ctl_ff;
  logic [7:0]       cnt_reg_ff [3];
  logic [7:0]       cnt_ctl_ff;
  logic [7:0]       xfer_chan_ff;
  logic [7:0]       irq_line_ff;
  logic             irq_pend_ff;
  logic             irq_prev_ff;
  logic             req_prev_ff;
  logic             ack_ff;
  logic             dma_req_ff;
  logic [7:0]       rdata_ff;
  logic             rdata_oe_ff;
  logic             timer_ff;
  logic             tmr_pulse;
  logic [7:0]       tmr_count;
  logic             tmr_load;
  logic [7:0]       tmr_reload;
  logic             irq_edge;
  logic             req_rise;
  logic             dir_a;
  logic             dir_b;

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  // The switch is captured after reset release, never at the asynchronous edge.
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_ff    <= pio_pkg::SW_DEFAULT;
      base_ld_ff <= 1'b0;
    end
    else if (!base_ld_ff)
    begin
      base_ff    <= base_sw_in;
      base_ld_ff <= 1'b1;
    end
  end

  function automatic logic in_window(input logic [9:0] a, input logic [5:0] b);
    in_window = (a >= pio_pkg::RANGE_LO) && (a <= pio_pkg::RANGE_HI) && (a[9:4] == b);
  endfunction : in_window

  assign hit       = base_ld_ff && in_window(io_addr_in, base_ff);
  assign acc.rd    = hit && io_rd_in;
  assign acc.wr    = hit && io_wr_in;
  assign acc.ofs   = io_addr_in[3:0];
  assign acc.wdata = io_wdata_in;

  assign dir_a = xfer_ctl_ff[pio_pkg::XC_DIR_A];
  // Word mode ties port B direction to port A.
  assign dir_b = xfer_ctl_ff[pio_pkg::XC_WORD] ? dir_a : xfer_ctl_ff[pio_pkg::XC_DIR_B];

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xfer_ctl_ff <= pio_pkg::CTL_RESET;
      irq_ctl_ff  <= pio_pkg::CTL_RESET;
    end
    else if (acc.wr)
    begin
      if (acc.ofs == pio_pkg::OFS_XFER_CTL)
        xfer_ctl_ff <= acc.wdata;
      if (acc.ofs == pio_pkg::OFS_IRQ_CTL)
        irq_ctl_ff <= acc.wdata;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_a_ff    <= pio_pkg::DATA_RESET;
      port_b_ff    <= pio_pkg::DATA_RESET;
      xfer_chan_ff <= pio_pkg::DATA_RESET;
      irq_line_ff  <= pio_pkg::DATA_RESET;
      cnt_ctl_ff   <= pio_pkg::DATA_RESET;
      for (int i = 0; i < 3; i++)
        cnt_reg_ff[i] <= pio_pkg::TIMER_RELOAD;
    end
    else if (acc.wr)
    begin
      unique case (acc.ofs)
        pio_pkg::OFS_PORT_A:    port_a_ff    <= acc.wdata;
        pio_pkg::OFS_PORT_B:    port_b_ff    <= acc.wdata;
        pio_pkg::OFS_CNT0:      cnt_reg_ff[0] <= acc.wdata;
        pio_pkg::OFS_CNT1:      cnt_reg_ff[1] <= acc.wdata;
        pio_pkg::OFS_CNT2:      cnt_reg_ff[2] <= acc.wdata;
        pio_pkg::OFS_CNT_CTL:   cnt_ctl_ff   <= acc.wdata;
        pio_pkg::OFS_XFER_CHAN: xfer_chan_ff <= acc.wdata;
        pio_pkg::OFS_IRQ_LINE:  irq_line_ff  <= acc.wdata;
        default:                ;
      endcase
    end
  end

  assign irq_edge = irq_ctl_ff[pio_pkg::IC_EDGE] ? (irq_pin_in && !irq_prev_ff)
                                                 : (!irq_pin_in && irq_prev_ff);

  // Reading interrupt status clears the pending flag, but a new edge wins.
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_prev_ff <= 1'b0;
      irq_pend_ff <= 1'b0;
    end
    else
    begin
      irq_prev_ff <= irq_pin_in;
      if (irq_edge)
        irq_pend_ff <= 1'b1;
      else if (acc.rd && acc.ofs == pio_pkg::OFS_IRQ_STATE)
        irq_pend_ff <= 1'b0;
    end
  end

  assign req_rise = transfer_request_in && !req_prev_ff;

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_prev_ff <= 1'b0;
      // The acknowledge pin idles high, so its flip-flop resets to one.
      ack_ff      <= 1'b1;
      dma_req_ff  <= 1'b0;
    end
    else
    begin
      req_prev_ff <= transfer_request_in;
      if (!xfer_ctl_ff[pio_pkg::XC_ENABLE])
      begin
        ack_ff     <= 1'b1;
        dma_req_ff <= 1'b0;
      end
      else if (ack_ff && req_rise && !xfer_ctl_ff[pio_pkg::XC_SRC])
      begin
        ack_ff     <= 1'b0;
        dma_req_ff <= 1'b1;
      end
      else if (!ack_ff && dma_ack_in)
      begin
        ack_ff     <= 1'b1;
        dma_req_ff <= 1'b0;
      end
    end
  end

  // A write must load the new value at once; the stored copy only updates on that same edge.
  assign tmr_load   = acc.wr && (acc.ofs == pio_pkg::OFS_CNT0);
  assign tmr_reload = tmr_load ? acc.wdata : cnt_reg_ff[0];

  // Only the first counter is wired to a pin; the others are plain storage.
  pio_timer u_timer
  (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n),
    .gate_in   (timer_gate_in),
    .load_in   (tmr_load),
    .reload_in (tmr_reload),
    .square_in (cnt_ctl_ff[1]),
    .pulse_out (tmr_pulse),
    .count_out (tmr_count)
  );

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
      timer_ff <= 1'b0;
    else
      timer_ff <= tmr_pulse;
  end

  function automatic logic [7:0] read_mux(input logic [3:0] ofs);
    unique case (ofs)
      pio_pkg::OFS_PORT_A:    read_mux = dir_a ? port_a_ff : port_a_lines_in;
      pio_pkg::OFS_PORT_B:    read_mux = dir_b ? port_b_ff : port_b_lines_in;
      pio_pkg::OFS_XFER_CTL:  read_mux = xfer_ctl_ff & pio_pkg::XC_RD_MASK;
      pio_pkg::OFS_IRQ_CTL:   read_mux = irq_ctl_ff & pio_pkg::IC_RD_MASK;
      pio_pkg::OFS_CNT0:      read_mux = tmr_count;
      pio_pkg::OFS_CNT1:      read_mux = cnt_reg_ff[1];
      pio_pkg::OFS_CNT2:      read_mux = cnt_reg_ff[2];
      pio_pkg::OFS_CNT_CTL:   read_mux = {timer_ff, timer_gate_in, cnt_ctl_ff[5:0]};
      pio_pkg::OFS_XFER_CHAN: read_mux = xfer_chan_ff;
      pio_pkg::OFS_IRQ_LINE:  read_mux = irq_line_ff;
      pio_pkg::OFS_IRQ_STATE: read_mux = {7'h00, irq_pend_ff};
      default:                read_mux = 8'h00;
    endcase
  endfunction : read_mux

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_ff    <= 8'h00;
      rdata_oe_ff <= 1'b0;
    end
    else
    begin
      rdata_ff    <= read_mux(acc.ofs);
      rdata_oe_ff <= acc.rd && (acc.ofs <= pio_pkg::OFS_IRQ_STATE);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_a_lines_out <= 8'h00;
      port_b_lines_out <= 8'h00;
      dir_a_out        <= 1'b0;
      dir_b_out        <= 1'b0;
      aux_out          <= 3'h0;
      irq_out          <= 1'b0;
      irq_oe_out       <= 1'b0;
      dma_req_oe_out   <= 1'b0;
    end
    else
    begin
      port_a_lines_out <= port_a_ff;
      port_b_lines_out <= port_b_ff;
      dir_a_out        <= dir_a;
      dir_b_out        <= dir_b;
      aux_out          <= {irq_ctl_ff[pio_pkg::IC_AUX3], xfer_ctl_ff[pio_pkg::XC_AUX2],
                           xfer_ctl_ff[pio_pkg::XC_AUX1]};
      irq_out          <= irq_pend_ff;
      irq_oe_out       <= irq_ctl_ff[pio_pkg::IC_ENABLE];
      dma_req_oe_out   <= xfer_ctl_ff[pio_pkg::XC_ENABLE];
    end
  end

  assign io_rdata_out     = rdata_ff;
  assign io_rdata_oe_out  = rdata_oe_ff;
  assign dma_req_out      = dma_req_ff;
  assign transfer_ack_out = ack_ff;
  assign timer_out        = timer_ff;

  a_unused_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (acc.rd && acc.ofs > pio_pkg::OFS_IRQ_STATE) |=> !io_rdata_oe_out)
    else $error("unused offset drove the data bus");

  a_outside_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (io_rd_in && (io_addr_in[9:4] != base_ff || io_addr_in < 10'h200)) |=> !io_rdata_oe_out)
    else $error("foreign address answered");

  sequence s_req_taken;
    xfer_ctl_ff[pio_pkg::XC_ENABLE] && !xfer_ctl_ff[pio_pkg::XC_SRC] && transfer_ack_out && req_rise;
  endsequence

  a_ack_falls: assert property (@(posedge mclk_in) disable iff (!rst_n)
    s_req_taken |=> !transfer_ack_out && dma_req_out)
    else $error("acknowledge did not fall on request");

  a_src_blocks: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (transfer_ack_out && xfer_ctl_ff[pio_pkg::XC_SRC]) |=> transfer_ack_out)
    else $error("transfer started with source bit set");

  a_ack_returns: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (!transfer_ack_out && dma_ack_in) |=> transfer_ack_out)
    else $error("acknowledge stayed low after completion");

  a_irq_edge_sel: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ($rose(irq_pin_in) && irq_ctl_ff[0]) |=> irq_pend_ff)
    else $error("selected interrupt edge lost");

  a_dir_follow: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ##1 (dir_a_out == $past(xfer_ctl_ff[0])))
    else $error("direction pin wrong");

  a_aux_follow: assert property (@(posedge mclk_in) disable iff (!rst_n)
    ##1 (aux_out[2] == $past(irq_ctl_ff[3]) && aux_out[0] == $past(xfer_ctl_ff[4])))
    else $error("aux pins do not follow control bits");

  a_req_tristate: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !xfer_ctl_ff[pio_pkg::XC_ENABLE] [*2] |-> !dma_req_oe_out)
    else $error("request line driven while disabled");

  a_gate_hold: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (!timer_gate_in && !(acc.wr && acc.ofs == pio_pkg::OFS_CNT0)) |=> $stable(tmr_count))
    else $error("timer counted with gate low");

endmodule : pio_card

// File: hdl/pio_pkg.sv
package pio_pkg;

  localparam int          ADDR_W        = 10;
  localparam int          DATA_W        = 8;
  localparam int          SW_W          = 6;
  localparam int          WIN_SIZE      = 16;
  localparam logic [9:0]  RANGE_LO      = 10'h200;
  localparam logic [9:0]  RANGE_HI      = 10'h3FF;
  localparam logic [5:0]  SW_DEFAULT    = 6'h30;

  localparam logic [3:0]  OFS_PORT_A    = 4'h0;
  localparam logic [3:0]  OFS_PORT_B    = 4'h1;
  localparam logic [3:0]  OFS_XFER_CTL  = 4'h2;
  localparam logic [3:0]  OFS_IRQ_CTL   = 4'h3;
  localparam logic [3:0]  OFS_CNT0      = 4'h4;
  localparam logic [3:0]  OFS_CNT1      = 4'h5;
  localparam logic [3:0]  OFS_CNT2      = 4'h6;
  localparam logic [3:0]  OFS_CNT_CTL   = 4'h7;
  localparam logic [3:0]  OFS_XFER_CHAN = 4'h8;
  localparam logic [3:0]  OFS_IRQ_LINE  = 4'h9;
  localparam logic [3:0]  OFS_IRQ_STATE = 4'hA;

  localparam int          XC_DIR_A      = 0;
  localparam int          XC_DIR_B      = 1;
  localparam int          XC_WORD       = 2;
  localparam int          XC_SRC        = 3;
  localparam int          XC_AUX1       = 4;
  localparam int          XC_AUX2       = 5;
  localparam int          XC_ENABLE     = 7;
  localparam logic [7:0]  XC_RD_MASK    = 8'hBF;

  localparam int          IC_EDGE       = 0;
  localparam int          IC_AUX3       = 3;
  localparam int          IC_ENABLE     = 7;
  localparam logic [7:0]  IC_RD_MASK    = 8'h8F;

  localparam logic [7:0]  CTL_RESET     = 8'h00;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [7:0]  TIMER_RELOAD  = 8'h02;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] ofs;
    logic [7:0] wdata;
  } pio_acc_t;

  typedef struct packed {
    logic dir_a;
    logic dir_b;
    logic aux1;
    logic aux2;
    logic aux3;
  } pio_pins_t;

endpackage : pio_pkg

// File: hdl/pio_timer.sv
module pio_timer
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       gate_in,
  input  wire logic       load_in,
  input  wire logic [7:0] reload_in,
  input  wire logic       square_in,
  output logic            pulse_out,
  output logic [7:0]      count_out
);

  logic [7:0] cnt_ff;
  logic       out_ff;

  // A low gate holds the count where it is; only a load can change it then.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      cnt_ff <= pio_pkg::DATA_RESET;
    else if (load_in)
      cnt_ff <= reload_in;
    else if (gate_in)
    begin
      if (cnt_ff <= 8'h01)
        cnt_ff <= reload_in;
      else
        cnt_ff <= cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      out_ff <= 1'b0;
    else if (!gate_in)
      out_ff <= square_in ? out_ff : 1'b0;
    else if (cnt_ff <= 8'h01)
      out_ff <= square_in ? ~out_ff : 1'b1;
    else
      out_ff <= square_in ? out_ff : 1'b0;
  end

  assign pulse_out = out_ff;
  assign count_out = cnt_ff;

endmodule : pio_timer

// File: testbench/pio_periph.sv
module pio_periph
(
  input  wire logic       mclk_in,
  input  wire logic       go_in,
  input  wire logic [3:0] delay_in,
  input  wire logic       transfer_ack_in,
  input  wire logic       dma_req_in,
  output logic            transfer_request_out,
  output logic            dma_ack_out,
  output logic [7:0]      data_out,
  output logic            done_out,
  output logic            seen_out,
  output logic [7:0]      low_cnt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int n;
  initial
  begin
    transfer_request_out = 1'b0;
    dma_ack_out = 1'b0;
    data_out = 8'h3C;
    done_out = 1'b0;
    seen_out = 1'b0;
    forever
    begin
      @(posedge mclk_in);
      done_out <= 1'b0;
      if (go_in === 1'b1)
      begin
        transfer_request_out <= 1'b1;
        n = 0;
        while (transfer_ack_in !== 1'b0 && n < 8)
        begin
          @(posedge mclk_in);
          n++;
        end
        seen_out <= (n < 8);
        if (n < 8)
        begin
          // The host side only finishes a transfer it was asked for, and may stall first.
          n = 0;
          while (dma_req_in !== 1'b1 && n < 8)
          begin
            @(posedge mclk_in);
            n++;
          end
          repeat (delay_in) @(posedge mclk_in);
          dma_ack_out <= (n < 8);
          @(posedge mclk_in);
          dma_ack_out <= 1'b0;
        end
        transfer_request_out <= 1'b0;
        n = 0;
        while (transfer_ack_in !== 1'b1 && n < 8)
        begin
          @(posedge mclk_in);
          n++;
        end
        data_out <= ~data_out;
        done_out <= 1'b1;
      end
    end
  end
  initial
  begin
    low_cnt_out = 8'h00;
    forever
    begin
      @(posedge mclk_in);
      if (transfer_ack_in === 1'b0)
        low_cnt_out <= low_cnt_out + 8'h01;
    end
  end
endmodule : pio_periph

// File: testbench/pio_card_bench.sv
module pio_card_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk_in, rst_n_in, io_rd_in, io_wr_in, irq_pin_in, timer_gate_in, go, dma_ack, xreq, done, seen;
  logic [9:0] io_addr_in;
  logic [7:0] io_wdata_in, rdata, pa_out, pb_out, pdata, low_cnt;
  logic [5:0] base_sw_in;
  logic [3:0] delay;
  logic       rdata_oe, dma_req, dma_req_oe, irq_out, irq_oe, ack, tmr, dir_a, dir_b;
  logic [2:0] aux;
  int         n_fail, compares, r, h;
  pio_card i_pio_card (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr_in), .io_rd_in(io_rd_in),
    .io_wr_in(io_wr_in), .io_wdata_in(io_wdata_in), .base_sw_in(base_sw_in), .dma_ack_in(dma_ack),
    .dma_tc_in(1'b0), .port_a_lines_in(dir_a ? pa_out : pdata), .port_b_lines_in(dir_b ? pb_out : ~pdata),
    .irq_pin_in(irq_pin_in), .transfer_request_in(xreq), .timer_gate_in(timer_gate_in),
    .io_rdata_out(rdata), .io_rdata_oe_out(rdata_oe), .dma_req_out(dma_req), .dma_req_oe_out(dma_req_oe),
    .irq_out(irq_out), .irq_oe_out(irq_oe), .port_a_lines_out(pa_out), .port_b_lines_out(pb_out),
    .transfer_ack_out(ack), .timer_out(tmr), .dir_a_out(dir_a), .dir_b_out(dir_b), .aux_out(aux));
  pio_periph i_pio_periph (.mclk_in(mclk_in), .go_in(go), .delay_in(delay), .transfer_ack_in(ack),
    .dma_req_in(dma_req), .transfer_request_out(xreq), .dma_ack_out(dma_ack), .data_out(pdata),
    .done_out(done), .seen_out(seen), .low_cnt_out(low_cnt));
  initial
  begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    io_addr_in <= a;
    io_wdata_in <= d;
    io_wr_in <= 1'b1;
    @(posedge mclk_in);
    io_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] m, input logic [7:0] exp, input logic oe);
    @(posedge mclk_in);
    io_addr_in <= a;
    io_rd_in <= 1'b1;
    @(posedge mclk_in);
    io_rd_in <= 1'b0;
    #1;
    check("read enable", {7'h00, oe}, {7'h00, rdata_oe});
    if (oe)
      check("read data", exp & m, rdata & m);
  endtask : rd
  task automatic pin(input logic v);
    @(posedge mclk_in);
    irq_pin_in <= v;
    repeat (3) @(posedge mclk_in);
  endtask : pin
  task automatic xfer(input logic [7:0] ctl, input logic [3:0] dly, input logic exp);
    logic [7:0] base;
    int         n;
    wr(10'h302, ctl);
    base = low_cnt;
    @(posedge mclk_in);
    go <= 1'b1;
    delay <= dly;
    @(posedge mclk_in);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60)
    begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    if (n >= 60)
    begin
      n_fail++;
      $display("mismatch transfer done expected 1 seen 0");
      close_out();
    end
    check("ack taken", {7'h00, exp}, {7'h00, seen});
    check("ack idle", 8'h01, {7'h00, ack});
    check("request idle", 8'h00, {7'h00, dma_req});
    if (exp)
      check("ack low span", 8'h01, {7'h00, (low_cnt - base) > {4'h0, dly}});
  endtask : xfer
  task automatic twatch;
    logic p;
    r = 0;
    h = 0;
    @(posedge mclk_in);
    #1;
    p = tmr;
    repeat (24)
    begin
      @(posedge mclk_in);
      #1;
      r += (tmr && !p);
      h += tmr;
      p = tmr;
    end
  endtask : twatch
  initial
  begin
    rst_n_in = 1'b0;
    io_rd_in = 1'b0;
    io_wr_in = 1'b0;
    io_addr_in = 10'h000;
    io_wdata_in = 8'h00;
    base_sw_in = 6'h30;
    irq_pin_in = 1'b0;
    timer_gate_in = 1'b1;
    go = 1'b0;
    delay = 4'h0;
    n_fail = 0;
    compares = 0;
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    check("ack at reset", 8'h01, {7'h00, ack});
    check("dirs at reset", 8'h00, {6'h00, dir_a, dir_b});
    check("request enable", 8'h00, {7'h00, dma_req_oe});
    rd(10'h302, 8'hFF, 8'h00, 1'b1);
    rd(10'h303, 8'hFF, 8'h00, 1'b1);
    $display("test reset done");
    rd(10'h312, 8'hFF, 8'h00, 1'b0);
    rd(10'h2F2, 8'hFF, 8'h00, 1'b0);
    wr(10'h312, 8'hFF);
    rd(10'h302, 8'hFF, 8'h00, 1'b1);
    $display("test decode done");
    wr(10'h302, 8'hFF);
    rd(10'h302, 8'hFF, 8'hBF, 1'b1);
    check("dirs out", 8'h03, {6'h00, dir_a, dir_b});
    check("aux", 8'h03, {5'h00, aux});
    check("request enable", 8'h01, {7'h00, dma_req_oe});
    wr(10'h303, 8'hF8);
    rd(10'h303, 8'hFF, 8'h88, 1'b1);
    check("aux", 8'h07, {5'h00, aux});
    wr(10'h302, 8'h01);
    @(posedge mclk_in);
    #1;
    check("dirs", 8'h02, {6'h00, dir_a, dir_b});
    check("aux", 8'h04, {5'h00, aux});
    wr(10'h300, 8'hA5);
    wr(10'h301, 8'h5A);
    @(posedge mclk_in);
    #1;
    check("port a pins", 8'hA5, pa_out);
    check("port b pins", 8'h5A, pb_out);
    rd(10'h300, 8'hFF, 8'hA5, 1'b1);
    rd(10'h301, 8'hFF, ~pdata, 1'b1);
    for (int o = 5; o < 10; o++)
    begin
      if (o != 7)
      begin
        wr({6'h30, o[3:0]}, 8'h5A ^ o[7:0]);
        rd({6'h30, o[3:0]}, 8'hFF, 8'h5A ^ o[7:0], 1'b1);
      end
    end
    wr(10'h30B, 8'hFF);
    rd(10'h30B, 8'hFF, 8'h00, 1'b0);
    rd(10'h30F, 8'hFF, 8'h00, 1'b0);
    rd(10'h302, 8'hFF, 8'h01, 1'b1);
    $display("test registers done");
    for (int e = 1; e >= 0; e--)
    begin
      pin(e == 0);
      wr(10'h303, 8'h80 | e[7:0]);
      rd(10'h30A, 8'h00, 8'h00, 1'b1);
      pin(e == 1);
      check("irq pins", 8'h03, {6'h00, irq_oe, irq_out});
      rd(10'h30A, 8'h01, 8'h01, 1'b1);
      pin(e == 0);
      rd(10'h30A, 8'h01, 8'h00, 1'b1);
    end
    $display("test interrupt done");
    xfer(8'h80, 4'h0, 1'b1);
    xfer(8'h80, 4'h6, 1'b1);
    xfer(8'h88, 4'h0, 1'b0);
    xfer(8'h00, 4'h0, 1'b0);
    check("request enable", 8'h00, {7'h00, dma_req_oe});
    $display("test transfer done");
    wr(10'h307, 8'h00);
    wr(10'h304, 8'h05);
    twatch();
    check("pulse seen", 8'h01, {7'h00, r > 0});
    check("pulse width", 8'h01, {7'h00, h == r});
    @(posedge mclk_in);
    timer_gate_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    twatch();
    check("held pulses", 8'h00, r[7:0]);
    rd(10'h307, 8'h40, 8'h00, 1'b1);
    @(posedge mclk_in);
    timer_gate_in <= 1'b1;
    wr(10'h307, 8'h02);
    wr(10'h304, 8'h05);
    repeat (4) @(posedge mclk_in);
    twatch();
    check("square", 8'h01, {7'h00, r > 0 && h > r});
    rd(10'h307, 8'h40, 8'h40, 1'b1);
    $display("test timer done");
    @(posedge mclk_in);
    base_sw_in <= 6'h20;
    rst_n_in   <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in   <= 1'b1;
    repeat (5) @(posedge mclk_in);
    rd(10'h203, 8'hFF, 8'h00, 1'b1);
    rd(10'h303, 8'hFF, 8'h00, 1'b0);
    $display("test base switch done");
    close_out();
  end
endmodule : pio_card_bench
